// ==== tcv_consts.vh ====
// Constants for the protective channel trip coincidence voter.
`ifndef TCV_CONSTS_VH
`define TCV_CONSTS_VH
// Default width of an analog sample.
`define TCV_W          16
// Default number of test switches.
`define TCV_TS         4
// Trip setpoints and the startup bypass level in analog sample units.
`define TCV_OVERPWR_SP 16'he000
`define TCV_TEMP_SP    16'hd000
`define TCV_PHI_SP     16'hf000
`define TCV_PLO_SP     16'h4000
`define TCV_STARTUP    16'h0800
// Flux to flow ratio, fraction in eight bits, and power ceiling.
`define TCV_RATIO      8'h8a
`define TCV_RATIO_SH   8
`define TCV_PMAX       16'hd800
// Imbalance dead band and slope, slope fraction in four bits.
`define TCV_IMB_KNEE   16'h1000
`define TCV_IMB_SLOPE  8'h18
`define TCV_IMB_SH     4
// Pressure-temperature comparator line.
`define TCV_PT_T0      16'h8000
`define TCV_PT_P0      16'h5000
`define TCV_PT_SLOPE   8'h02
// Power limits for reduced pump combinations.
`define TCV_LIM_P3     16'ha000
`define TCV_LIM_P2     16'h6000
`define TCV_LIM_LOW    16'h0000
// Bit positions of the function trip vector.
`define TCV_F_OVP      0
`define TCV_F_FLI      1
`define TCV_F_PMP      2
`define TCV_F_TMP      3
`define TCV_F_PT       4
`define TCV_F_PHI      5
`define TCV_F_PLO      6
`define TCV_F_TRB      7
`define TCV_F_FW       8
`define TCV_F_BLD      9
`define TCV_NF         10
// Service unit register indices and enable bits.
`define TCV_SA_EN      2'h0
`define TCV_SA_FT      2'h1
`define TCV_SA_AL      2'h2
`define TCV_SA_PC      2'h3
`define TCV_EN_TRB     0
`define TCV_EN_FW      1
`define TCV_EN_RST     2'h3
`endif

// ==== tcv_voter.v ====
// Trip decision and coincidence voting logic for one protective channel.
`timescale 1ns/100ps
`include "tcv_consts.vh"

module tcv_voter #(
    parameter W  = `TCV_W,
    parameter TS = `TCV_TS
) (
    input  wire              clk,
    input  wire              rstn,
    // Index 0 of each four-wide group is this channel's own signal.
    input  wire [4*W-1:0]    lin_flux,
    input  wire [3:0]        flux_bad,
    input  wire [4*W-1:0]    outlet_temp,
    input  wire [3:0]        temp_bad,
    input  wire [4*W-1:0]    cool_press,
    input  wire [3:0]        press_bad,
    input  wire [W-1:0]      flux_upper,
    input  wire [W-1:0]      flux_lower,
    input  wire [2*W-1:0]    loop_dp,
    input  wire [2:0]        link_ok,
    input  wire [2:0]        peer_trip,
    input  wire              turb_contact,
    input  wire [2:0]        turb_peer,
    input  wire [7:0]        fw_contacts,
    input  wire [3:0]        bldg_contacts,
    input  wire [3:0]        coolant_pump_run,
    input  wire [TS-1:0]     test_sw_off,
    input  wire              flux_psu_fail,
    input  wire              shutdown_bypass,
    input  wire              manual_bypass,
    input  wire              svc_wr,
    input  wire [1:0]        svc_addr,
    input  wire [15:0]       svc_wdata,
    output reg  [15:0]       svc_rdata_r,
    output reg  [15:0]       plant_computer_r,
    output reg  [`TCV_NF-1:0] func_trip_r,
    output reg               chan_trip_r,
    output reg               reactor_trip_r,
    output reg               trouble_r,
    output reg               on_test_r,
    output reg               psu_fail_r,
    output reg               sdb_init_r,
    output reg               mbp_init_r,
    output reg               turb_share_r,
    output reg  [2:0]        pump_cnt_r
);

    // Width of the bundle of external inputs that must be synchronised:
    // sixteen samples wide in all (three groups of four, two chambers and
    // two loops) plus the flag and contact bits and the test switches.
    // The concatenations below must agree with this count bit for bit.
    localparam NB = 16*W + 41 + TS;

    reg  [NB-1:0] sync1_r;
    reg  [NB-1:0] sync2_r;
    reg  [1:0]    en_r;
    wire [NB-1:0] raw;

    // Every input in raw passes two flip-flops; the first feeds only the second.
    // Reset clears both stages, so for two edges after release low readings
    // may show a short channel trip, which errs on the safe side.
    assign raw = {lin_flux, flux_bad, outlet_temp, temp_bad, cool_press,
                  press_bad, flux_upper, flux_lower, loop_dp, link_ok,
                  peer_trip, turb_contact, turb_peer, fw_contacts,
                  bldg_contacts, coolant_pump_run, test_sw_off,
                  flux_psu_fail, shutdown_bypass, manual_bypass};

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= {NB{1'b0}};
            sync2_r <= {NB{1'b0}};
        end else begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
        end
    end

    wire [4*W-1:0] s_flux;
    wire [3:0]     s_flux_bad;
    wire [4*W-1:0] s_temp;
    wire [3:0]     s_temp_bad;
    wire [4*W-1:0] s_press;
    wire [3:0]     s_press_bad;
    wire [W-1:0]   s_up;
    wire [W-1:0]   s_lo;
    wire [2*W-1:0] s_dp;
    wire [2:0]     s_link;
    wire [2:0]     s_ptrip;
    wire           s_turb;
    wire [2:0]     s_turb_peer;
    wire [7:0]     s_fw;
    wire [3:0]     s_bldg;
    wire [3:0]     s_pump;
    wire [TS-1:0]  s_test;
    wire           s_psu;
    wire           s_sdb;
    wire           s_mbp;

    assign {s_flux, s_flux_bad, s_temp, s_temp_bad, s_press, s_press_bad,
            s_up, s_lo, s_dp, s_link, s_ptrip, s_turb, s_turb_peer, s_fw,
            s_bldg, s_pump, s_test, s_psu, s_sdb, s_mbp} = sync2_r;

    // Own signal is hardwired; peer signals need their link alive.
    // A peer entry behind a dead link may hold stale or random data.
    wire [3:0] link4 = {s_link, 1'b1};

    // Second maximum (hi) or second minimum over valid entries. With one
    // valid entry it passes through; with none it returns the value that
    // trips, so a channel that has lost all inputs fails safe.
    function [W-1:0] sel2;
        input [4*W-1:0] v;
        input [3:0]     ok;
        input           hi;
        reg   [W-1:0]   a;
        reg   [W-1:0]   b;
        reg   [W-1:0]   x;
        reg   [2:0]     n;
        integer         i;
        begin
            a = {W{1'b1}};
            b = {W{1'b0}};
            n = 3'h0;
            for (i = 0; i < 4; i = i + 1) begin
                if (ok[i]) begin
                    x = hi ? v[i*W +: W] : ~v[i*W +: W];
                    if (n == 3'h0) begin
                        a = x;
                    end else if (x > a) begin
                        b = a;
                        a = x;
                    end else if (n == 3'h1 || x > b) begin
                        b = x;
                    end
                    n = n + 3'h1;
                end
            end
            sel2 = (n >= 3'h2) ? b : a;
            if (!hi) begin
                sel2 = ~sel2;
            end
        end
    endfunction

    // Two-of-four over valid contacts; lost entries drop out, so the
    // vote becomes two-of-three without further logic.
    function vote2;
        input [3:0] hit;
        input [3:0] ok;
        reg   [3:0] m;
        begin
            m = hit & ok;
            vote2 = (m[0] + m[1] + m[2] + m[3]) >= 2;
        end
    endfunction

    wire [W-1:0] flux2 = sel2(s_flux, ~s_flux_bad & link4, 1'b1);
    wire [W-1:0] temp2 = sel2(s_temp, ~s_temp_bad & link4, 1'b1);
    wire [W-1:0] pmax2 = sel2(s_press, ~s_press_bad & link4, 1'b1);
    wire [W-1:0] pmin2 = sel2(s_press, ~s_press_bad & link4, 1'b0);

    // Total flux and imbalance from the upper and lower chambers.
    // Total flux is formed for the record only; the setpoints compare
    // against the selected flux, which already sees both chambers.
    wire [W:0]   flux_tot = {1'b0, s_up} + {1'b0, s_lo};
    wire [W:0]   imb      = {1'b0, s_up} - {1'b0, s_lo};
    wire [W:0]   imb_abs  = imb[W] ? (~imb + 1'b1) : imb;

    // Total flow is the sum of both loops. The carry bit is kept so that
    // two loops near full scale cannot wrap round to a small flow.
    wire [W:0]   flow_tot = {1'b0, s_dp[W-1:0]} +
                            {1'b0, s_dp[2*W-1:W]};

    // Flow times ratio, clamped to the thermal power ceiling.
    wire [W+8:0] flow_x   = flow_tot * `TCV_RATIO;
    wire [W+8:0] base_w   = flow_x >> `TCV_RATIO_SH;
    wire [W-1:0] base     = (base_w > `TCV_PMAX) ? `TCV_PMAX
                                                 : base_w[W-1:0];

    // Imbalance beyond the dead band pulls the setpoint down; the floor at
    // zero means a large imbalance trips at any power.
    wire [W:0]   imb_ex   = (imb_abs > `TCV_IMB_KNEE) ?
                            imb_abs - `TCV_IMB_KNEE : {(W+1){1'b0}};
    wire [W+8:0] red_x    = imb_ex * `TCV_IMB_SLOPE;
    wire [W+8:0] red      = red_x >> `TCV_IMB_SH;
    wire [W-1:0] fi_sp    = ({9'h0, base} > red) ?
                            base - red[W-1:0] : {W{1'b0}};

    // Pump monitor: two pumps per loop, loop A in bits 1:0.
    wire [1:0]   cnt_a    = s_pump[0] + s_pump[1];
    wire [1:0]   cnt_b    = s_pump[2] + s_pump[3];
    wire [2:0]   pcnt     = cnt_a + cnt_b;
    reg  [W-1:0] pump_lim;

    // Allowed power per pump combination; two pumps in one loop trips.
    // A zero limit trips at any measurable flux, which is the safe answer
    // when too few pumps run or both running pumps share one loop.
    always @* begin
        case (pcnt)
            3'h4:    pump_lim = {W{1'b1}};
            3'h3:    pump_lim = `TCV_LIM_P3;
            3'h2:    pump_lim = (cnt_a == 2'h1) ? `TCV_LIM_P2 : `TCV_LIM_LOW;
            default: pump_lim = `TCV_LIM_LOW;
        endcase
    end

    // Pressure limit line rising with outlet temperature.
    wire [2*W-1:0] pt_x   = (temp2 > `TCV_PT_T0) ?
                            (temp2 - `TCV_PT_T0) * `TCV_PT_SLOPE : {2*W{1'b0}};
    wire [2*W-1:0] pt_lim = pt_x + `TCV_PT_P0;
    wire           pt_cmp = {{W{1'b0}}, pmin2} < pt_lim;

    // Contact voting; an open contact reads as one.
    wire [3:0]   turb4    = {s_turb_peer, s_turb};
    wire         fw_a     = vote2(s_fw[3:0], link4);
    wire         fw_b     = vote2(s_fw[7:4], link4);
    wire [3:0]   bm       = s_bldg & link4;
    wire [2:0]   b_open   = bm[0] + bm[1] + bm[2] + bm[3];
    wire         startup  = flux2 < `TCV_STARTUP;

    reg  [`TCV_NF-1:0] ft_nxt;

    // Function trips, all evaluated afresh each cycle.
    // Flux, temperature and pressure functions read selected values; the contact
    // trips vote raw linked entries, and chamber, flow and pump inputs are single readings.
    always @* begin
        ft_nxt = {`TCV_NF{1'b0}};
        ft_nxt[`TCV_F_OVP] = flux2 > `TCV_OVERPWR_SP;
        ft_nxt[`TCV_F_FLI] = flux2 > fi_sp;
        ft_nxt[`TCV_F_PMP] = flux2 > pump_lim;
        ft_nxt[`TCV_F_TMP] = temp2 > `TCV_TEMP_SP;
        ft_nxt[`TCV_F_PHI] = pmax2 > `TCV_PHI_SP;
        ft_nxt[`TCV_F_PLO] = pmin2 < `TCV_PLO_SP;
        ft_nxt[`TCV_F_PT]  = pt_cmp | ft_nxt[`TCV_F_TMP] |
                             ft_nxt[`TCV_F_PHI] | ft_nxt[`TCV_F_PLO];
        ft_nxt[`TCV_F_TRB] = en_r[`TCV_EN_TRB] & ~startup &
                             vote2(turb4, link4);
        ft_nxt[`TCV_F_FW]  = en_r[`TCV_EN_FW] & ~startup &
                             fw_a & fw_b;
        ft_nxt[`TCV_F_BLD] = b_open >= 3'h2;
    end

    // Own trip plus linked peer trips; a lost link drops that channel.
    // The own vote uses the registered channel trip, the same level the
    // siblings receive, at the cost of one more cycle of latency.
    wire       own_trip = |ft_nxt;
    wire [3:0] tv       = {s_ptrip & s_link, chan_trip_r};
    wire       vote_nxt = (tv[0] + tv[1] + tv[2] + tv[3]) >= 2;

    wire       test_nxt = |s_test;
    wire       trbl_nxt = (b_open == 3'h1);
    wire [5:0] al_nxt   = {mbp_init_r, sdb_init_r, psu_fail_r,
                           on_test_r, trouble_r, chan_trip_r};

    // Registered trip, vote and alarm outputs.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            func_trip_r    <= {`TCV_NF{1'b0}};
            chan_trip_r    <= 1'b0;
            reactor_trip_r <= 1'b0;
            trouble_r      <= 1'b0;
            on_test_r      <= 1'b0;
            psu_fail_r     <= 1'b0;
            sdb_init_r     <= 1'b0;
            mbp_init_r     <= 1'b0;
            turb_share_r   <= 1'b0;
            pump_cnt_r     <= 3'h0;
        end else begin
            func_trip_r    <= ft_nxt;
            chan_trip_r    <= own_trip;
            reactor_trip_r <= vote_nxt;
            trouble_r      <= trbl_nxt;
            on_test_r      <= test_nxt;
            psu_fail_r     <= s_psu;
            sdb_init_r     <= s_sdb;
            mbp_init_r     <= s_mbp;
            turb_share_r   <= s_turb;
            pump_cnt_r     <= pcnt;
        end
    end

    // Plant computer gets a status word only; nothing comes back from it.
    // The word lags the trip flags by one cycle, the price of taking it
    // straight from a flip-flop.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            plant_computer_r <= 16'h0000;
        end else begin
            plant_computer_r <= {al_nxt, func_trip_r};
        end
    end

    // Service unit: writes trip enables, reads status back.
    // Both enables reset to one, so the trips are armed from power-up
    // even if the service unit never writes.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_r <= `TCV_EN_RST;
        end else if (svc_wr && svc_addr == `TCV_SA_EN) begin
            en_r <= svc_wdata[1:0];
        end
    end

    // Read data follows the address one cycle later.
    // The service unit runs on this clock, so its address needs no
    // synchroniser.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            svc_rdata_r <= 16'h0000;
        end else begin
            case (svc_addr)
                `TCV_SA_EN: svc_rdata_r <= {14'h0, en_r};
                `TCV_SA_FT: svc_rdata_r <= {6'h0, func_trip_r};
                `TCV_SA_AL: svc_rdata_r <= {7'h0, pump_cnt_r, al_nxt};
                default:    svc_rdata_r <= flux2[W-1:W-16];
            endcase
        end
    end

endmodule // tcv_voter

// ==== tcv_peer_model.sv ====
// Behavioural model of the three sibling channels across the data links.
`timescale 1ns/100ps
module tcv_peer_model (
    input  wire       clk,
    input  wire [2:0] set_trip,
    input  wire [2:0] set_turb,
    input  wire [2:0] set_link,
    output reg  [2:0] link_ok,
    output reg  [2:0] peer_trip,
    output reg  [2:0] turb_peer
);
    // Each frame a live link carries the sibling's trip and turbine contact.
    // A dead link carries junk that flips every frame, so a channel that
    // still leans on it shows up at once instead of by luck.
    always @(posedge clk) begin
        link_ok   <= set_link;
        peer_trip <= (set_link & set_trip) |
                     (~set_link & ~peer_trip);
        turb_peer <= (set_link & set_turb) |
                     (~set_link & ~turb_peer);
    end
endmodule // tcv_peer_model

// ==== tcv_voter_sva.sv ====
// Concurrent checks on the ports of the trip coincidence voter.
`timescale 1ns/100ps
`include "tcv_consts.vh"
module tcv_voter_sva #(
    parameter W  = 16,
    parameter TS = 4
) (
    input wire [0:0]   clk,
    input wire [0:0]   rstn,
    input wire [4*W-1:0] lin_flux,
    input wire [3:0]   flux_bad,
    input wire [2:0]   link_ok,
    input wire [2:0]   peer_trip,
    input wire         turb_contact,
    input wire [3:0]   bldg_contacts,
    input wire [3:0]   coolant_pump_run,
    input wire [TS-1:0] test_sw_off,
    input wire [15:0]  plant_computer_r,
    input wire [`TCV_NF-1:0] func_trip_r,
    input wire         chan_trip_r,
    input wire         reactor_trip_r,
    input wire         trouble_r,
    input wire         on_test_r,
    input wire         psu_fail_r,
    input wire         sdb_init_r,
    input wire         mbp_init_r,
    input wire         turb_share_r,
    input wire [2:0]   pump_cnt_r
);
    // Inputs must hold six cycles, five for the turbine contact, enough to cross the synchronisers.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    peer_vote_a: assert property (
        (&peer_trip[1:0] && &link_ok[1:0])[*6] |-> reactor_trip_r)
        else $error("two linked peer trips gave no reactor trip");
    lone_peer_a: assert property (
        (link_ok == 3'h7 && peer_trip == 3'h1 && !chan_trip_r)[*6]
        |-> !reactor_trip_r) else $error("one trip alone tripped reactor");
    link_loss_a: assert property (
        (link_ok == 3'h0 && !chan_trip_r)[*6] |-> !reactor_trip_r)
        else $error("unlinked peers were counted in the vote");
    chan_or_a: assert property (
        $stable(func_trip_r)[*2] |-> chan_trip_r == (|func_trip_r))
        else $error("channel trip is not the OR of function trips");
    bldg_one_a: assert property (
        (bldg_contacts == 4'h1)[*6] |-> trouble_r && !func_trip_r[`TCV_F_BLD])
        else $error("single building contact handled wrongly");
    bldg_two_a: assert property (
        (bldg_contacts == 4'h3 && link_ok[0])[*6]
        |-> func_trip_r[`TCV_F_BLD]) else $error("two contacts gave no trip");
    test_alarm_a: assert property (
        $stable(test_sw_off)[*6] |-> on_test_r == (|test_sw_off))
        else $error("test alarm does not follow the switches");
    plant_map_a: assert property (
        $stable({func_trip_r, chan_trip_r, trouble_r, on_test_r, psu_fail_r,
        sdb_init_r, mbp_init_r})[*2] |-> plant_computer_r == {mbp_init_r,
        sdb_init_r, psu_fail_r, on_test_r, trouble_r, chan_trip_r,
        func_trip_r}) else $error("plant computer word is wrong");
    pump_count_a: assert property (
        $stable(coolant_pump_run)[*6]
        |-> pump_cnt_r == $countones(coolant_pump_run))
        else $error("running pump count is wrong");
    overpower_a: assert property (
        (lin_flux[2*W-1:0] == {2*W{1'b1}} && link_ok[0] && !flux_bad[0]
        && !flux_bad[1])[*6] |-> func_trip_r[`TCV_F_OVP])
        else $error("overpower trip missing");
    startup_a: assert property (
        (lin_flux == {4*W{1'b0}} && flux_bad == 4'h0)[*6]
        |-> !func_trip_r[`TCV_F_TRB] && !func_trip_r[`TCV_F_FW])
        else $error("turbine or feedwater trip not bypassed");
    turb_share_a: assert property (
        $stable(turb_contact)[*5] |-> turb_share_r == turb_contact)
        else $error("shared turbine contact is wrong");

    cover property (reactor_trip_r && !chan_trip_r);
    cover property (trouble_r);
    cover property (func_trip_r[`TCV_F_FW]);
endmodule // tcv_voter_sva

bind tcv_voter tcv_voter_sva #(.W(W), .TS(TS)) u_sva (
    .clk(clk), .rstn(rstn), .lin_flux(lin_flux), .flux_bad(flux_bad),
    .link_ok(link_ok), .peer_trip(peer_trip), .turb_contact(turb_contact),
    .bldg_contacts(bldg_contacts), .coolant_pump_run(coolant_pump_run),
    .test_sw_off(test_sw_off), .plant_computer_r(plant_computer_r),
    .func_trip_r(func_trip_r), .chan_trip_r(chan_trip_r),
    .reactor_trip_r(reactor_trip_r), .trouble_r(trouble_r),
    .on_test_r(on_test_r), .psu_fail_r(psu_fail_r), .sdb_init_r(sdb_init_r),
    .mbp_init_r(mbp_init_r), .turb_share_r(turb_share_r),
    .pump_cnt_r(pump_cnt_r));

// ==== trip_coincidence_voter_tb.sv ====
// Self-checking bench for the trip coincidence voter.
`timescale 1ns/100ps
`include "tcv_consts.vh"
`define CHK(g, e, m) begin checks = checks + 1; if ((g) !== (e)) begin \
    err_total = err_total + 1; \
    $display("CHECK FAILED at %0t: %s", $time, m); end end
module trip_coincidence_voter_tb;
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg  [63:0] lin_flux, outlet_temp, cool_press;
    reg  [15:0] flux_upper, flux_lower, svc_wdata;
    reg  [31:0] loop_dp;
    reg  [3:0]  flux_bad, temp_bad, press_bad, bldg, pumps, test_sw;
    reg  [7:0]  fw;
    reg  [2:0]  set_trip, set_turb, set_link;
    reg         turb, psu, sdb, mbp, svc_wr;
    reg  [1:0]  svc_addr;
    wire [15:0] svc_rdata_r, plant_computer_r;
    wire [9:0]  func_trip_r;
    wire        chan_trip_r, reactor_trip_r, trouble_r, on_test_r;
    wire        psu_fail_r, sdb_init_r, mbp_init_r, turb_share_r;
    wire [2:0]  pump_cnt_r, link_ok, peer_trip, turb_peer;
    integer     err_total = 0, checks = 0, cyc = 0;

    tcv_voter #(.W(16), .TS(4)) DUT (
        .clk(clk), .rstn(rstn), .lin_flux(lin_flux), .flux_bad(flux_bad),
        .outlet_temp(outlet_temp), .temp_bad(temp_bad),
        .cool_press(cool_press), .press_bad(press_bad),
        .flux_upper(flux_upper), .flux_lower(flux_lower), .loop_dp(loop_dp),
        .link_ok(link_ok), .peer_trip(peer_trip), .turb_contact(turb),
        .turb_peer(turb_peer), .fw_contacts(fw), .bldg_contacts(bldg),
        .coolant_pump_run(pumps), .test_sw_off(test_sw),
        .flux_psu_fail(psu), .shutdown_bypass(sdb), .manual_bypass(mbp),
        .svc_wr(svc_wr), .svc_addr(svc_addr), .svc_wdata(svc_wdata),
        .svc_rdata_r(svc_rdata_r), .plant_computer_r(plant_computer_r),
        .func_trip_r(func_trip_r), .chan_trip_r(chan_trip_r),
        .reactor_trip_r(reactor_trip_r), .trouble_r(trouble_r),
        .on_test_r(on_test_r), .psu_fail_r(psu_fail_r),
        .sdb_init_r(sdb_init_r), .mbp_init_r(mbp_init_r),
        .turb_share_r(turb_share_r), .pump_cnt_r(pump_cnt_r));

    tcv_peer_model peers (.clk(clk), .set_trip(set_trip), .set_turb(set_turb),
        .set_link(set_link), .link_ok(link_ok), .peer_trip(peer_trip),
        .turb_peer(turb_peer));

    // Free-running 250 MHz clock.
    always #2 clk = ~clk;

    // Cycle ceiling; the whole sequence needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            close_out;
        end
    end

    task close_out;
        begin
            $display("Comparisons %0d, mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // Quiet plant: all values inside their limits, four pumps, links up.
    task set_idle;
        begin
            lin_flux    = {4{16'h1000}};
            outlet_temp = {4{16'h8000}};
            cool_press  = {4{16'h8000}};
            loop_dp     = {2{16'h6000}};
            {flux_upper, flux_lower} = {2{16'h0800}};
            {flux_bad, temp_bad, press_bad, bldg, test_sw, fw} = 28'h0;
            {set_trip, set_turb, turb, psu, sdb, mbp, svc_wr} = 11'h0;
            {pumps, set_link, svc_addr, svc_wdata} = {4'hf, 3'h7, 18'h0};
        end
    endtask

    // Inputs have to cross two synchronisers and a register stage.
    task settle;
        begin
            repeat (6) @(posedge clk);
            #1;
        end
    endtask

    task trip_is(input [9:0] exp);
        begin
            settle;
            `CHK(func_trip_r, exp, "function trips")
            `CHK(chan_trip_r, |exp, "channel trip")
        end
    endtask

    // A service write is a single-cycle strobe.
    task svc_write(input [1:0] a, input [15:0] d);
        begin
            {svc_wr, svc_addr, svc_wdata} = {1'b1, a, d};
            @(posedge clk);
            #1;
            svc_wr = 1'b0;
        end
    endtask

    task svc_read(input [1:0] a, input [15:0] exp);
        begin
            svc_addr = a;
            repeat (2) @(posedge clk);
            #1;
            `CHK(svc_rdata_r, exp, "service read")
        end
    endtask

    initial begin
        set_idle;
        repeat (5) @(posedge clk);
        #1;
        rstn = 1'b1;
        trip_is(10'h000);
        `CHK(pump_cnt_r, 3'h4, "pump count")
        lin_flux[15:0] = 16'hffff;
        trip_is(10'h000);
        lin_flux[31:16] = 16'hffff;
        trip_is(10'h003);
        flux_bad = 4'h2;
        trip_is(10'h000);
        {flux_bad, set_link} = {4'h0, 3'h6};
        trip_is(10'h000);
        set_idle;
        {loop_dp, lin_flux} = {{2{16'h2000}}, {4{16'h5000}}};
        trip_is(10'h002);
        {loop_dp, lin_flux} = {{2{16'hf000}}, {4{16'hdc00}}};
        trip_is(10'h002);
        {flux_upper, flux_lower, lin_flux} = {32'h1000_9000, {4{16'h5000}}};
        trip_is(10'h002);
        {flux_upper, flux_lower, loop_dp} = {32'h1800_0800, {2{16'h6000}}};
        trip_is(10'h000);
        {pumps, lin_flux} = {4'h3, {4{16'h1000}}};
        trip_is(10'h004);
        `CHK(pump_cnt_r, 3'h2, "pump count")
        pumps = 4'h5;
        trip_is(10'h000);
        set_idle;
        outlet_temp[31:0] = {2{16'he000}};
        trip_is(10'h018);
        set_idle;
        cool_press[31:0] = {2{16'hf800}};
        trip_is(10'h030);
        cool_press[31:0] = {2{16'h3000}};
        trip_is(10'h050);
        set_idle;
        turb = 1'b1;
        trip_is(10'h000);
        `CHK(turb_share_r, 1'b1, "shared contact")
        set_turb = 3'h1;
        trip_is(10'h080);
        svc_write(`TCV_SA_EN, 16'h0002);
        trip_is(10'h000);
        svc_read(`TCV_SA_EN, 16'h0002);
        svc_write(`TCV_SA_FT, 16'hffff);
        svc_read(`TCV_SA_EN, 16'h0002);
        svc_write(`TCV_SA_EN, 16'h0003);
        fw = 8'h33;
        trip_is(10'h180);
        lin_flux = 64'h0;
        trip_is(10'h000);
        set_idle;
        fw = 8'h03;
        trip_is(10'h000);
        bldg = 4'h1;
        trip_is(10'h000);
        `CHK(trouble_r, 1'b1, "trouble alarm")
        {bldg, set_trip} = {4'h3, 3'h1};
        trip_is(10'h200);
        `CHK(reactor_trip_r, 1'b1, "own plus one peer")
        {bldg, set_trip, set_link} = {4'h0, 3'h3, 3'h5};
        trip_is(10'h000);
        `CHK(reactor_trip_r, 1'b0, "lost link voted")
        set_link = 3'h7;
        settle;
        `CHK(reactor_trip_r, 1'b1, "two peers")
        set_trip = 3'h1;
        settle;
        `CHK(reactor_trip_r, 1'b0, "one peer alone")
        {set_trip, set_link} = {3'h7, 3'h0};
        trip_is(10'h000);
        `CHK(reactor_trip_r, 1'b0, "dead links voted")
        set_idle;
        {test_sw, psu, sdb, mbp} = {4'h8, 3'h7};
        settle;
        `CHK(plant_computer_r, 16'hf000, "plant word")
        `CHK(on_test_r, 1'b1, "test alarm flag")
        svc_read(`TCV_SA_AL, 16'h013c);
        test_sw = 4'h0;
        settle;
        `CHK(plant_computer_r, 16'he000, "test alarm")
        close_out;
    end
endmodule // trip_coincidence_voter_tb
